// *** common/spt_pkg.sv ***
// Shared constants and types for the lane bit-error and transport self-test block.
// Assumes an Avalon-MM host with 32-bit data and byte addresses, one register per word.

package spt_pkg;

  // ****************************************************************
  // Bus and datapath geometry
  // ****************************************************************
  localparam int unsigned SPT_ADDR_W  = 12;
  localparam int unsigned SPT_DATA_W  = 32;
  localparam int unsigned SPT_IDX_W   = 10;
  localparam int unsigned SPT_LANES   = 8;
  localparam int unsigned SPT_SAMP_W  = 16;
  localparam int unsigned SPT_SAMPLES = 4;
  localparam int unsigned SPT_CONVS   = 2;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] SPT_IDX_LANE_EN  = 10'h315;
  localparam logic [9:0] SPT_IDX_CTRL     = 10'h316;
  localparam logic [9:0] SPT_IDX_THR_LO   = 10'h317;
  localparam logic [9:0] SPT_IDX_THR_MID  = 10'h318;
  localparam logic [9:0] SPT_IDX_THR_HI   = 10'h319;
  localparam logic [9:0] SPT_IDX_CNT_LO   = 10'h31A;
  localparam logic [9:0] SPT_IDX_CNT_MID  = 10'h31B;
  localparam logic [9:0] SPT_IDX_CNT_HI   = 10'h31C;
  localparam logic [9:0] SPT_IDX_PASS     = 10'h31D;
  localparam logic [9:0] SPT_IDX_TPL_CTRL = 10'h32C;
  localparam logic [9:0] SPT_IDX_REF_LO   = 10'h32D;
  localparam logic [9:0] SPT_IDX_REF_HI   = 10'h32E;
  localparam logic [9:0] SPT_IDX_TPL_RES  = 10'h32F;
  localparam logic [9:0] SPT_IDX_IRQ_STAT = 10'h340;
  localparam logic [9:0] SPT_IDX_IRQ_MASK = 10'h341;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SPT_CTRL_RESET_BIT = 0;
  localparam int unsigned SPT_CTRL_RUN_BIT   = 1;
  localparam int unsigned SPT_CTRL_PAT_LSB   = 2;
  localparam int unsigned SPT_CTRL_SRC_LSB   = 4;
  localparam int unsigned SPT_TPL_EN_BIT     = 0;
  localparam int unsigned SPT_TPL_CLR_BIT    = 1;
  localparam int unsigned SPT_TPL_CONV_LSB   = 2;
  localparam int unsigned SPT_TPL_SAMP_LSB   = 4;
  localparam int unsigned SPT_IRQ_LANE_BIT   = 0;
  localparam int unsigned SPT_IRQ_TPL_BIT    = 1;

  // ****************************************************************
  // Reset values and limits
  // ****************************************************************
  localparam logic [7:0]  SPT_RST_BYTE = 8'h00;
  localparam logic [7:0]  SPT_RST_PASS = 8'hFF;
  localparam logic [23:0] SPT_CNT_MAX  = 24'hFFFFFF;

  // ****************************************************************
  // Pattern codes and checker warm-up lengths in bits
  // ****************************************************************
  localparam logic [1:0] SPT_PAT_PRBS7  = 2'h0;
  localparam logic [1:0] SPT_PAT_PRBS15 = 2'h1;
  localparam logic [1:0] SPT_PAT_PRBS31 = 2'h2;
  localparam logic [4:0] SPT_FILL_PRBS7  = 5'h07;
  localparam logic [4:0] SPT_FILL_PRBS15 = 5'h0F;
  localparam logic [4:0] SPT_FILL_PRBS31 = 5'h1F;

  // Checker sequencing
  typedef enum logic [1:0] {
    SPT_IDLE,
    SPT_FILL,
    SPT_CHECK
  } spt_state_t;

endpackage

// *** core/spt_core.sv ***
// Lane PRBS bit-error checker and short transport sample check with register file.
// Assumes lane bits and converter samples come from deserializer logic clocked on mclk.
//
// Decided for this implementation: the Avalon-MM interface to the registers.

module spt_core (
  input  wire logic                                 mclk,
  input  wire logic                                 resetn,
  input  wire logic [spt_pkg::SPT_ADDR_W-1:0]       avs_address,
  input  wire logic                                 avs_read,
  input  wire logic                                 avs_write,
  input  wire logic [spt_pkg::SPT_DATA_W-1:0]       avs_writedata,
  input  wire logic [3:0]                           avs_byteenable,
  output logic      [spt_pkg::SPT_DATA_W-1:0]       avs_readdata,
  output logic                                      avs_waitrequest,
  input  wire logic [spt_pkg::SPT_LANES-1:0]        lane_rx_bit,
  input  wire logic                                 sample_valid,
  input  wire logic [spt_pkg::SPT_CONVS*spt_pkg::SPT_SAMPLES*spt_pkg::SPT_SAMP_W-1:0]
                                                    conv_samples,
  output logic                                      irq
);
  import spt_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [SPT_IDX_W-1:0] idx;
  logic                 req;
  logic                 wr_fire;
  logic                 rd_take;
  logic [7:0]           wbyte;
  logic [7:0]           rd_byte;

  logic [7:0]           lane_test_enables;
  logic                 bert_reset;
  logic                 bert_run;
  logic [1:0]           pattern_select;
  logic [2:0]           count_lane_select;
  logic [23:0]          error_threshold;
  logic [15:0]          count_snap;

  logic                 transport_check_enable;
  logic [1:0]           converter_select;
  logic [1:0]           sample_index_select;
  logic [7:0]           reference_low_byte;
  logic [7:0]           reference_high_byte;
  logic                 transport_mismatch_flag;
  logic                 tpl_clear;
  logic                 tpl_mismatch;
  logic [SPT_SAMP_W-1:0] sel_sample;
  logic [6:0]           sel_base;

  logic [1:0]           irq_status;
  logic [1:0]           irq_mask;
  logic [1:0]           irq_events;
  logic [1:0]           next_irq_status;

  spt_state_t           state;
  logic [4:0]           fill_cnt;
  logic [4:0]           fill_len;

  logic [30:0]          lane_hist [SPT_LANES];
  logic [23:0]          error_count [SPT_LANES];
  logic [7:0]           lane_pass_flags;
  logic [7:0]           next_pass;
  logic [23:0]          cnt_sel;

  // ****************************************************************
  // Avalon-MM slave handshake
  // ****************************************************************

  // Word index and qualified strobes
  assign idx     = avs_address[SPT_ADDR_W-1:2];
  assign req     = avs_read | avs_write;
  assign rd_take = avs_read & avs_waitrequest;
  assign wr_fire = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wbyte   = avs_writedata[7:0];

  // One wait cycle per access, then one ready cycle, then back to waiting
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data latched as waitrequest drops, so it stands at the completing edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // Read multiplexer; unmapped words and reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      SPT_IDX_LANE_EN:  rd_byte = lane_test_enables;
      SPT_IDX_CTRL:     rd_byte = {1'b0, count_lane_select, pattern_select, bert_run, bert_reset};
      SPT_IDX_THR_LO:   rd_byte = error_threshold[7:0];
      SPT_IDX_THR_MID:  rd_byte = error_threshold[15:8];
      SPT_IDX_THR_HI:   rd_byte = error_threshold[23:16];
      SPT_IDX_CNT_LO:   rd_byte = cnt_sel[7:0];
      SPT_IDX_CNT_MID:  rd_byte = count_snap[7:0];
      SPT_IDX_CNT_HI:   rd_byte = count_snap[15:8];
      SPT_IDX_PASS:     rd_byte = lane_pass_flags;
      SPT_IDX_TPL_CTRL: rd_byte = {2'b00, sample_index_select, converter_select,
                                   1'b0, transport_check_enable};
      SPT_IDX_REF_LO:   rd_byte = reference_low_byte;
      SPT_IDX_REF_HI:   rd_byte = reference_high_byte;
      SPT_IDX_TPL_RES:  rd_byte = {7'h00, transport_mismatch_flag};
      SPT_IDX_IRQ_STAT: rd_byte = {6'h00, irq_status};
      SPT_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default:          rd_byte = 8'h00;
    endcase
  end

  // Upper count bytes frozen when the low byte is read, so a 24-bit read does not tear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_snap <= 16'h0000;
    end else if (rd_take && idx == SPT_IDX_CNT_LO) begin
      count_snap <= cnt_sel[23:8];
    end
  end

  // ****************************************************************
  // Lane test control registers
  // ****************************************************************

  // Enables, control byte and threshold bytes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lane_test_enables <= SPT_RST_BYTE;
      bert_reset        <= 1'b0;
      bert_run          <= 1'b0;
      pattern_select    <= SPT_PAT_PRBS7;
      count_lane_select <= 3'h0;
      error_threshold   <= 24'h000000;
    end else if (wr_fire) begin
      case (idx)
        SPT_IDX_LANE_EN: lane_test_enables <= wbyte;
        SPT_IDX_CTRL: begin
          bert_reset        <= wbyte[SPT_CTRL_RESET_BIT];
          bert_run          <= wbyte[SPT_CTRL_RUN_BIT];
          pattern_select    <= wbyte[SPT_CTRL_PAT_LSB +: 2];
          count_lane_select <= wbyte[SPT_CTRL_SRC_LSB +: 3];
        end
        SPT_IDX_THR_LO:  error_threshold[7:0]   <= wbyte;
        SPT_IDX_THR_MID: error_threshold[15:8]  <= wbyte;
        SPT_IDX_THR_HI:  error_threshold[23:16] <= wbyte;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Checker sequencer
  // ****************************************************************

  // Warm-up length: the local history must hold a full register of received bits
  always_comb begin
    fill_len = SPT_FILL_PRBS7;
    case (pattern_select)
      SPT_PAT_PRBS15: fill_len = SPT_FILL_PRBS15;
      SPT_PAT_PRBS31: fill_len = SPT_FILL_PRBS31;
      default:        fill_len = SPT_FILL_PRBS7;
    endcase
  end

  // Idle until run, fill the history, then check until run drops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state    <= SPT_IDLE;
      fill_cnt <= 5'h00;
    end else if (bert_reset) begin
      state    <= SPT_IDLE;
      fill_cnt <= 5'h00;
    end else begin
      unique case (state)
        SPT_IDLE: begin
          fill_cnt <= 5'h00;
          if (bert_run) begin
            state <= SPT_FILL;
          end
        end
        SPT_FILL: begin
          if (!bert_run) begin
            state <= SPT_IDLE;
          end else if (fill_cnt == fill_len) begin
            state <= SPT_CHECK;
          end else begin
            fill_cnt <= fill_cnt + 5'h01;
          end
        end
        SPT_CHECK: begin
          if (!bert_run) begin
            state <= SPT_IDLE;
          end
        end
        default: begin
          state <= SPT_IDLE;                                // Unused code falls back to idle
        end
      endcase
    end
  end

  // ****************************************************************
  // Per-lane self-synchronising checkers
  // ****************************************************************

  // Expected bit from the received history for the chosen polynomial
  function automatic logic spt_predict(input logic [30:0] hist, input logic [1:0] pat);
    logic bit_out;
    bit_out = hist[6] ^ hist[5];
    case (pat)
      SPT_PAT_PRBS15: bit_out = hist[14] ^ hist[13];
      SPT_PAT_PRBS31: bit_out = hist[30] ^ hist[27];
      default:        bit_out = hist[6] ^ hist[5];
    endcase
    return bit_out;
  endfunction

  for (genvar g = 0; g < SPT_LANES; g++) begin : g_lane
    logic lane_err;

    // Mismatch between the received bit and the sequence predicted from past bits
    assign lane_err = lane_rx_bit[g] ^ spt_predict(lane_hist[g], pattern_select);

    // Received history shifts while the sequencer is active on an enabled lane
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        lane_hist[g] <= 31'h00000000;
      end else if (bert_reset) begin
        lane_hist[g] <= 31'h00000000;
      end else if (state != SPT_IDLE && lane_test_enables[g]) begin
        lane_hist[g] <= {lane_hist[g][29:0], lane_rx_bit[g]};
      end
    end

    // Saturating error counter, held at zero by the checker reset
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        error_count[g] <= 24'h000000;
      end else if (bert_reset) begin
        error_count[g] <= 24'h000000;
      end else if (state == SPT_CHECK && lane_test_enables[g] && lane_err
                   && error_count[g] != SPT_CNT_MAX) begin
        error_count[g] <= error_count[g] + 24'h000001;
      end
    end

    // Pass while below threshold
    assign next_pass[g] = (error_count[g] < error_threshold);
  end

  // Pass flags start all set
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lane_pass_flags <= SPT_RST_PASS;
    end else begin
      lane_pass_flags <= next_pass;
    end
  end

  // Count of the lane chosen for readback
  assign cnt_sel = error_count[count_lane_select];

  // ****************************************************************
  // Short transport sample check
  // ****************************************************************

  // Control and reference bytes; the clear bit is a write strobe only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transport_check_enable <= 1'b0;
      converter_select       <= 2'h0;
      sample_index_select    <= 2'h0;
      reference_low_byte     <= SPT_RST_BYTE;
      reference_high_byte    <= SPT_RST_BYTE;
    end else if (wr_fire) begin
      case (idx)
        SPT_IDX_TPL_CTRL: begin
          transport_check_enable <= wbyte[SPT_TPL_EN_BIT];
          converter_select       <= wbyte[SPT_TPL_CONV_LSB +: 2];
          sample_index_select    <= wbyte[SPT_TPL_SAMP_LSB +: 2];
        end
        SPT_IDX_REF_LO: reference_low_byte  <= wbyte;
        SPT_IDX_REF_HI: reference_high_byte <= wbyte;
        default: ;
      endcase
    end
  end

  // Converter picked by the upper select bit, then sample x of its frame
  assign sel_base   = {converter_select[1], sample_index_select, 4'h0};
  assign sel_sample = conv_samples[sel_base +: SPT_SAMP_W];

  // Compare only while enabled and a frame is presented
  assign tpl_mismatch = transport_check_enable & sample_valid
                      & (sel_sample != {reference_high_byte, reference_low_byte});
  assign tpl_clear    = wr_fire & (idx == SPT_IDX_TPL_CTRL) & wbyte[SPT_TPL_CLR_BIT];

  // Sticky result; a mismatch in the clearing cycle wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transport_mismatch_flag <= 1'b0;
    end else if (tpl_mismatch) begin
      transport_mismatch_flag <= 1'b1;
    end else if (tpl_clear) begin
      transport_mismatch_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************

  // Events: a lane losing its pass flag, the transport result turning to fail
  assign irq_events[SPT_IRQ_LANE_BIT] = |(lane_pass_flags & ~next_pass);
  assign irq_events[SPT_IRQ_TPL_BIT]  = tpl_mismatch & ~transport_mismatch_flag;

  // Write one to clear, new events win over the clear
  always_comb begin
    next_irq_status = irq_status;
    if (wr_fire && idx == SPT_IDX_IRQ_STAT) begin
      next_irq_status = irq_status & ~wbyte[1:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  // Status and mask registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_fire && idx == SPT_IDX_IRQ_MASK) begin
        irq_mask <= wbyte[1:0];
      end
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

// *** dv/spt_core_props.sv ***
// Concurrent checks on the self-test block's ports.
// Assumes attachment by bind to spt_core, one clock domain.
module spt_core_props
  import spt_pkg::*;
(
  input wire logic                          mclk,
  input wire logic                          resetn,
  input wire logic [SPT_ADDR_W-1:0]         avs_address,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [SPT_DATA_W-1:0]         avs_writedata,
  input wire logic [3:0]                    avs_byteenable,
  input wire logic [SPT_DATA_W-1:0]         avs_readdata,
  input wire logic                          avs_waitrequest,
  input wire logic [SPT_LANES-1:0]          lane_rx_bit,
  input wire logic                          sample_valid,
  input wire logic [SPT_CONVS*SPT_SAMPLES*SPT_SAMP_W-1:0] conv_samples,
  input wire logic                          irq
);
  // ****************************************************************
  // Mirror of the transport and mask settings seen on the bus
  // ****************************************************************
  logic [7:0]  tpl_m;
  logic [15:0] ref_m;
  logic [7:0]  mask_m;
  logic        res_m;
  wire logic [9:0]  idx = avs_address[11:2];
  wire logic        done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic [15:0] sel_s = conv_samples[{tpl_m[3], tpl_m[5:4], 4'h0} +: 16];

  // Update mirrors at the completing edge of each write that enables byte lane 0
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tpl_m  <= 8'h00;
      ref_m  <= 16'h0000;
      mask_m <= 8'h00;
    end else if (done) begin
      if (idx == SPT_IDX_TPL_CTRL) tpl_m <= avs_writedata[7:0];
      if (idx == SPT_IDX_REF_LO) ref_m[7:0] <= avs_writedata[7:0];
      if (idx == SPT_IDX_REF_HI) ref_m[15:8] <= avs_writedata[7:0];
      if (idx == SPT_IDX_IRQ_MASK) mask_m <= avs_writedata[7:0];
    end
  end

  // Mirror of the sticky transport result: a miss sets it, a clear write drops it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      res_m <= 1'b0;
    end else if (tpl_m[0] && sample_valid && sel_s != ref_m) begin
      res_m <= 1'b1;
    end else if (done && idx == SPT_IDX_TPL_CTRL && avs_writedata[1]) begin
      res_m <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence bus_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence tpl_miss;
    tpl_m[0] && sample_valid && (sel_s != ref_m) && mask_m[1] && !res_m;
  endsequence

  wait_answer_a: assert property (bus_take |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("readdata changed without read");
  rdata_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("readdata upper bits not zero");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest && idx == 10'h3FF
    |=> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  irq_masked_a: assert property (mask_m == 8'h00 |=> !irq)
    else $error("irq high with all sources masked");
  tpl_fail_irq_a: assert property (tpl_miss |-> ##2 irq)
    else $error("sample mismatch did not raise irq");
endmodule

// *** dv/spt_lane_src.sv ***
// Far-end pattern source: drives the same pseudo-random bit on all lanes.
// Assumes pattern and flip are driven off the clock edge by the bench.
module spt_lane_src
  import spt_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [1:0]  pattern,
  input wire logic [7:0]  flip,
  output logic     [7:0]  lane_rx_bit
);
  logic [30:0] hist;
  logic        next_bit;

  // Feedback taps of the chosen polynomial
  always_comb begin
    next_bit = pattern == SPT_PAT_PRBS15 ? hist[14] ^ hist[13] :
               pattern == SPT_PAT_PRBS31 ? hist[30] ^ hist[27] : hist[6] ^ hist[5];
  end

  // Line errors are injected after the generator, history stays clean
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hist        <= 31'h12345671;
      lane_rx_bit <= 8'h00;
    end else begin
      hist        <= {hist[29:0], next_bit};
      lane_rx_bit <= {8{next_bit}} ^ flip;
    end
  end
endmodule

// *** dv/spt_core_bench.sv ***
// Self-checking bench for the lane bit-error and transport self-test block.
// Assumes spt_core, spt_lane_src and spt_core_props are compiled before it.
module spt_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spt_pkg::*;

  typedef struct packed {logic [9:0] idx; logic [7:0] wd; logic [7:0] ex;} spt_row_t;

  logic         mclk, resetn, avs_read, avs_write, sample_valid, irq, avs_waitrequest;
  logic [11:0]  avs_address;
  logic [31:0]  avs_writedata, avs_readdata;
  logic [3:0]   avs_byteenable;
  logic [7:0]   lane_rx_bit, flip;
  logic [1:0]   pattern;
  logic [127:0] conv_samples;
  int           failures, checks;
  spt_row_t     rows [8] = '{'{SPT_IDX_THR_LO, 8'h03, 8'h03}, '{SPT_IDX_THR_MID, 8'hC3, 8'hC3},
    '{SPT_IDX_THR_HI, 8'h3C, 8'h3C}, '{SPT_IDX_REF_LO, 8'hA5, 8'hA5},
    '{SPT_IDX_REF_HI, 8'h5A, 8'h5A}, '{SPT_IDX_LANE_EN, 8'h0F, 8'h0F},
    '{SPT_IDX_CNT_HI, 8'hFF, 8'h00}, '{10'h3FF, 8'h77, 8'h00}};

  spt_core spt_core_inst (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lane_rx_bit(lane_rx_bit),
    .sample_valid(sample_valid), .conv_samples(conv_samples), .irq(irq));
  spt_lane_src spt_lane_src_inst (.mclk(mclk), .resetn(resetn), .pattern(pattern),
    .flip(flip), .lane_rx_bit(lane_rx_bit));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ****************************************************************
  // Bus, stimulus and compare tasks
  // ****************************************************************
  task automatic bus(input logic wr_n, input logic [9:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge mclk);
    avs_address   <= {i, 2'b00};
    avs_write     <= wr_n;
    avs_read      <= !wr_n;
    avs_writedata <= {24'h000000, d};
    // Hold until waitrequest is seen low at a rising edge; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] ex);
    checks++;
    if (got !== ex) begin
      failures++;
      $display("FAIL at %0t: read %h, expected %h", $time, got, ex);
    end
  endtask
  task automatic chk1(input logic ex);
    checks++;
    if (irq !== ex) begin
      failures++;
      $display("FAIL at %0t: irq %b, expected %b", $time, irq, ex);
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rd_chk(input logic [9:0] i, input logic [7:0] ex);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk8(q, ex);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One bit error on lanes 0 and 7 for a single cycle
  task automatic hit();
    @(posedge mclk);
    flip <= 8'h81;
    @(posedge mclk);
    flip <= 8'h00;
  endtask
  // One frame: only=1 spoils the chosen slot, only=0 spoils every other slot
  task automatic frame(input int sel, input logic only);
    @(posedge mclk);
    for (int k = 0; k < 8; k++)
      conv_samples[k*16 +: 16] <= ((k == sel) == only) ? 16'h5AA4 : 16'h5AA5;
    sample_valid <= 1'b1;
    @(posedge mclk);
    sample_valid <= 1'b0;
    tick(3);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {resetn, avs_read, avs_write, sample_valid} = 4'h0;
    {avs_address, avs_writedata, conv_samples, flip, pattern} = '0;
    avs_byteenable = 4'hF;
    failures = 0;
    checks = 0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].idx, rows[k].wd);
      rd_chk(rows[k].idx, rows[k].ex);
    end
    // A write with byte lane 0 disabled is acked but stores nothing
    avs_byteenable <= 4'hE;
    wr(SPT_IDX_REF_LO, 8'h11);
    avs_byteenable <= 4'hF;
    rd_chk(SPT_IDX_REF_LO, 8'hA5);
    wr(SPT_IDX_IRQ_MASK, 8'h03);
    wr(SPT_IDX_THR_MID, 8'h00);
    wr(SPT_IDX_THR_HI, 8'h00);
    for (int p = 0; p < 3; p++) begin
      pattern <= 2'(p);
      wr(SPT_IDX_CTRL, 8'h01);
      rd_chk(SPT_IDX_CNT_LO, 8'h00);
      wr(SPT_IDX_CTRL, 8'(p * 4 + 2));
      tick(40);
      hit();
      tick(40);  // Bad bit must pass both feedback taps before all three errors count
      rd_chk(SPT_IDX_CNT_LO, 8'h03);
      rd_chk(SPT_IDX_CNT_MID, 8'h00);
      rd_chk(SPT_IDX_PASS, 8'hFE);
      wr(SPT_IDX_CTRL, 8'(p * 4));
      hit();
      tick(4);
      rd_chk(SPT_IDX_CNT_LO, 8'h03);
    end
    wr(SPT_IDX_CTRL, 8'h70);
    rd_chk(SPT_IDX_CNT_LO, 8'h00);
    for (int c = 0; c < 2; c++)
      for (int s = 0; s < 4; s++) begin
        wr(SPT_IDX_TPL_CTRL, 8'(s * 16 + c * 8 + 3));
        frame(c * 4 + s, 1'b0);
        rd_chk(SPT_IDX_TPL_RES, 8'h00);
        frame(c * 4 + s, 1'b1);
        rd_chk(SPT_IDX_TPL_RES, 8'h01);
      end
    wr(SPT_IDX_TPL_CTRL, 8'h00);
    rd_chk(SPT_IDX_TPL_RES, 8'h01);
    wr(SPT_IDX_TPL_CTRL, 8'h02);
    rd_chk(SPT_IDX_TPL_RES, 8'h00);
    frame(0, 1'b1);
    rd_chk(SPT_IDX_TPL_RES, 8'h00);
    rd_chk(SPT_IDX_IRQ_STAT, 8'h03);
    chk1(1'b1);
    wr(SPT_IDX_IRQ_STAT, 8'h03);
    rd_chk(SPT_IDX_IRQ_STAT, 8'h00);
    tick(2);
    chk1(1'b0);
    wr(SPT_IDX_IRQ_MASK, 8'h00);
    wr(SPT_IDX_TPL_CTRL, 8'h01);
    frame(0, 1'b1);
    chk1(1'b0);
    rd_chk(SPT_IDX_IRQ_STAT, 8'h02);
    wr(SPT_IDX_IRQ_MASK, 8'h02);
    tick(2);
    chk1(1'b1);
    @(posedge mclk);
    resetn <= 1'b0;
    tick(2);
    @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(SPT_IDX_THR_LO, 8'h00);
    rd_chk(SPT_IDX_REF_HI, 8'h00);
    rd_chk(SPT_IDX_IRQ_MASK, 8'h00);
    report_and_stop();
  end

  // Cut a hang short
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
endmodule

bind spt_core spt_core_props spt_core_props_inst (.mclk(mclk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .lane_rx_bit(lane_rx_bit), .sample_valid(sample_valid),
  .conv_samples(conv_samples), .irq(irq));
